/* File: src/cvt_calib_regs.sv */
/*
 * calibration vector port and factory trim registers on a wishbone slave
 * assumes calibration engine drives the halted status; vector entries are loaded through the bus port
 */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - enable bit 0 gates vector port
// - enable register resets to zero
// - each port read returns next entry
// - each port write with lane 0 selected loads next entry
// - short sequence leaves vector invalid
// - channel A eight-bit gain trim
// - channel B eight-bit gain trim
// - band-gap trim four bits, upper reserved
// - first input termination trim
// - second input termination trim
// - trims reset to factory, writable
// - core A timing adjust register
// - timing adjust shifts core sampling instant
module cvt_calib_regs
    import cvt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CVT_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic calibration_halted_status_i,
    output logic [7:0] gain_trim_first_channel_o,
    output logic [7:0] gain_trim_second_channel_o,
    output logic [3:0] bandgap_reference_trim_o,
    output logic [7:0] termination_trim_first_input_o,
    output logic [7:0] termination_trim_second_input_o,
    output logic [7:0] core_a_timing_adjust_fg_single_o,
    output logic vector_valid_o
);
    cvt_bus_state_t state_q;
    logic [7:0] enable_q;
    logic [7:0] gain_a_q;
    logic [7:0] gain_b_q;
    logic [7:0] bg_q;
    logic [7:0] term_a_q;
    logic [7:0] term_b_q;
    logic [7:0] tadj_q;
    logic [CVT_IDX_W-1:0] vidx_q;
    logic valid_q;
    logic partial_q;
    logic [31:0] rdata_q;
    logic [7:0] vec_rdata;
    logic req;
    logic take;
    logic port_on;
    logic port_hit;
    logic lane0_wr;
    logic [7:0] reg_idx;

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
        return idx == target;
    endfunction

    assign reg_idx = wb_adr_i[CVT_ADR_W-1:2];
    assign req = wb_cyc_i && wb_stb_i;
    assign take = req && (state_q == CVT_IDLE);
    assign lane0_wr = take && wb_we_i && wb_sel_i[0];
    assign port_on = enable_q[CVT_ENABLE_BIT];
    assign port_hit = take && port_on && hit(reg_idx, CVT_IDX_PORT);

    // bus handshake, ack one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= CVT_IDLE;
        end else begin
            case (state_q)
                CVT_IDLE: begin
                    if (req) begin
                        state_q <= CVT_ACK;
                    end
                end
                CVT_ACK: state_q <= CVT_IDLE;
                default: state_q <= CVT_IDLE;
            endcase
        end
    end
    assign wb_ack_o = (state_q == CVT_ACK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q <= CVT_ENABLE_RESET;
        end else if (lane0_wr && hit(reg_idx, CVT_IDX_ENABLE)) begin
            enable_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gain_a_q <= CVT_FACT_GAIN_A;
            gain_b_q <= CVT_FACT_GAIN_B;
            bg_q <= CVT_FACT_BG;
            term_a_q <= CVT_FACT_TERM_A;
            term_b_q <= CVT_FACT_TERM_B;
            tadj_q <= CVT_FACT_TADJ;
        end else if (lane0_wr) begin
            if (hit(reg_idx, CVT_IDX_GAIN_A)) begin
                gain_a_q <= wb_dat_i[7:0];
            end
            if (hit(reg_idx, CVT_IDX_GAIN_B)) begin
                gain_b_q <= wb_dat_i[7:0];
            end
            if (hit(reg_idx, CVT_IDX_BG)) begin
                bg_q <= wb_dat_i[7:0] & CVT_BG_MASK;
            end
            if (hit(reg_idx, CVT_IDX_TERM_A)) begin
                term_a_q <= wb_dat_i[7:0];
            end
            if (hit(reg_idx, CVT_IDX_TERM_B)) begin
                term_b_q <= wb_dat_i[7:0];
            end
            if (hit(reg_idx, CVT_IDX_TADJ)) begin
                tadj_q <= wb_dat_i[7:0];
            end
        end
    end

    // timing adjust drives core sampling delay
    assign core_a_timing_adjust_fg_single_o = tadj_q;
    assign gain_trim_first_channel_o = gain_a_q;
    assign gain_trim_second_channel_o = gain_b_q;
    assign bandgap_reference_trim_o = bg_q[CVT_BG_W-1:0];
    assign termination_trim_first_input_o = term_a_q;
    assign termination_trim_second_input_o = term_b_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vidx_q <= '0;
        end else if (lane0_wr && hit(reg_idx, CVT_IDX_ENABLE) && wb_dat_i[CVT_ENABLE_BIT] && !port_on) begin
            vidx_q <= '0;
        end else if (port_hit) begin
            vidx_q <= (vidx_q == CVT_VEC_LAST) ? '0 : vidx_q + 10'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
            partial_q <= 1'b0;
        end else if (port_hit) begin
            partial_q <= (vidx_q != CVT_VEC_LAST);
            if (wb_we_i) begin
                valid_q <= (vidx_q == CVT_VEC_LAST) && !partial_q ? 1'b1 : (vidx_q == CVT_VEC_LAST);
            end else begin
                valid_q <= valid_q;
            end
            if (wb_we_i && vidx_q != CVT_VEC_LAST) begin
                valid_q <= 1'b0;
            end
        end else if (take && hit(reg_idx, CVT_IDX_ENABLE) && wb_we_i && partial_q) begin
            valid_q <= 1'b0;
        end
    end
    assign vector_valid_o = valid_q;

    cvt_vector_store u_store (
        .clk_i(clk_i),
        .we_i(port_hit && wb_we_i && wb_sel_i[0]),
        .idx_i(vidx_q),
        .wdata_i(wb_dat_i[7:0]),
        .rdata_o(vec_rdata)
    );

    // read data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (take) begin
            rdata_q <= '0;
            if (hit(reg_idx, CVT_IDX_ENABLE)) rdata_q[7:0] <= enable_q;
            if (hit(reg_idx, CVT_IDX_PORT) && port_on) rdata_q[7:0] <= vec_rdata;
            if (hit(reg_idx, CVT_IDX_GAIN_A)) rdata_q[7:0] <= gain_a_q;
            if (hit(reg_idx, CVT_IDX_GAIN_B)) rdata_q[7:0] <= gain_b_q;
            if (hit(reg_idx, CVT_IDX_BG)) rdata_q[7:0] <= bg_q;
            if (hit(reg_idx, CVT_IDX_TERM_A)) rdata_q[7:0] <= term_a_q;
            if (hit(reg_idx, CVT_IDX_TERM_B)) rdata_q[7:0] <= term_b_q;
            if (hit(reg_idx, CVT_IDX_TADJ)) rdata_q[7:0] <= tadj_q;
            if (hit(reg_idx, CVT_IDX_STATUS)) begin
                rdata_q[CVT_ST_HALTED] <= calibration_halted_status_i;
                rdata_q[CVT_ST_DONE] <= valid_q;
                rdata_q[CVT_ST_PARTIAL] <= partial_q;
            end
        end
    end
    assign wb_dat_o = rdata_q;

    // assertions
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
        take |=> wb_ack_o)
        else $error("request not acknowledged next cycle");

    a_port_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && !port_on) |=> $stable(vidx_q) || vidx_q == '0)
        else $error("index moved while port closed");

    a_enable_reset: assert property (@(posedge clk_i)
        rst_i |=> enable_q == 8'h00)
        else $error("enable not zero after reset");

    a_index_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (port_hit && vidx_q != CVT_VEC_LAST) |=> vidx_q == $past(vidx_q) + 10'h001)
        else $error("index did not advance by one");

    a_index_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (port_hit && vidx_q == CVT_VEC_LAST) |=> vidx_q == '0)
        else $error("index did not wrap after last entry");

    a_bg_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
        bg_q[7:4] == 4'h0)
        else $error("band-gap reserved bits set");

    a_gain_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (lane0_wr && reg_idx == CVT_IDX_GAIN_A) |=> gain_trim_first_channel_o == $past(wb_dat_i[7:0]))
        else $error("gain A write lost");

    a_trim_reset: assert property (@(posedge clk_i)
        rst_i |=> termination_trim_second_input_o == CVT_FACT_TERM_B && core_a_timing_adjust_fg_single_o == CVT_FACT_TADJ)
        else $error("trim not factory after reset");

    a_partial_invalid: assert property (@(posedge clk_i) disable iff (rst_i)
        (port_hit && wb_we_i && vidx_q != CVT_VEC_LAST) |=> !vector_valid_o)
        else $error("partial write left vector valid");

    a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> $past(take))
        else $error("ack without a taken request");

    a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (lane0_wr && reg_idx == CVT_IDX_ENABLE) |=> enable_q == $past(wb_dat_i[7:0]))
        else $error("enable write lost");

    a_enable_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(lane0_wr && reg_idx == CVT_IDX_ENABLE) |=> $stable(enable_q))
        else $error("enable changed without a write");

    a_sel_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && wb_we_i && !wb_sel_i[0]) |=> $stable(enable_q))
        else $error("write with lane zero off changed enable");

    a_gain_b_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (lane0_wr && reg_idx == CVT_IDX_GAIN_B) |=> gain_trim_second_channel_o == $past(wb_dat_i[7:0]))
        else $error("gain B write lost");

    a_bg_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (lane0_wr && reg_idx == CVT_IDX_BG) |=> bandgap_reference_trim_o == $past(wb_dat_i[3:0]))
        else $error("band-gap write lost");

    a_term_a_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (lane0_wr && reg_idx == CVT_IDX_TERM_A) |=> termination_trim_first_input_o == $past(wb_dat_i[7:0]))
        else $error("first termination write lost");

    a_term_b_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (lane0_wr && reg_idx == CVT_IDX_TERM_B) |=> termination_trim_second_input_o == $past(wb_dat_i[7:0]))
        else $error("second termination write lost");

    a_tadj_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (lane0_wr && reg_idx == CVT_IDX_TADJ) |=> core_a_timing_adjust_fg_single_o == $past(wb_dat_i[7:0]))
        else $error("timing adjust write lost");

    a_tadj_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(lane0_wr && reg_idx == CVT_IDX_TADJ) |=> $stable(core_a_timing_adjust_fg_single_o))
        else $error("timing adjust moved without a write");

    a_gain_a_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(lane0_wr && reg_idx == CVT_IDX_GAIN_A) |=> $stable(gain_trim_first_channel_o))
        else $error("gain A moved without a write");

    a_gain_b_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(lane0_wr && reg_idx == CVT_IDX_GAIN_B) |=> $stable(gain_trim_second_channel_o))
        else $error("gain B moved without a write");

    a_bg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(lane0_wr && reg_idx == CVT_IDX_BG) |=> $stable(bandgap_reference_trim_o))
        else $error("band-gap moved without a write");

    a_term_a_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(lane0_wr && reg_idx == CVT_IDX_TERM_A) |=> $stable(termination_trim_first_input_o))
        else $error("first termination moved without a write");

    a_term_b_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(lane0_wr && reg_idx == CVT_IDX_TERM_B) |=> $stable(termination_trim_second_input_o))
        else $error("second termination moved without a write");

    a_index_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        (lane0_wr && reg_idx == CVT_IDX_ENABLE && wb_dat_i[CVT_ENABLE_BIT] && !port_on) |=> vidx_q == '0)
        else $error("index did not restart on enable");

    a_closed_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && reg_idx == CVT_IDX_PORT && !port_on) |=> wb_dat_o == 32'h0)
        else $error("closed port returned data");

    a_read_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");

    a_port_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (port_hit && !wb_we_i) |=> wb_dat_o[7:0] == $past(vec_rdata))
        else $error("port read returned wrong entry");

    a_valid_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (port_hit && wb_we_i && wb_sel_i[0] && vidx_q == CVT_VEC_LAST) |=> vector_valid_o)
        else $error("full write sequence not marked valid");

    a_status_halted: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && reg_idx == CVT_IDX_STATUS) |=> wb_dat_o[CVT_ST_HALTED] == $past(calibration_halted_status_i))
        else $error("status halted bit wrong");

    a_status_done: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && reg_idx == CVT_IDX_STATUS) |=> wb_dat_o[CVT_ST_DONE] == $past(valid_q))
        else $error("status valid bit wrong");
endmodule // cvt_calib_regs
`default_nettype wire

/* File: inc/cvt_pkg.sv */
/*
 * constants for the calibration vector and trim register bank
 * assumes a classic wishbone slave with 32-bit data, one register per word
 */
package cvt_pkg;
    // printed offsets are register indices; byte address is four times index
    localparam logic [7:0] CVT_IDX_ENABLE = 8'h70;
    localparam logic [7:0] CVT_IDX_PORT = 8'h71;
    localparam logic [7:0] CVT_IDX_GAIN_A = 8'h7a;
    localparam logic [7:0] CVT_IDX_GAIN_B = 8'h7b;
    localparam logic [7:0] CVT_IDX_BG = 8'h7c;
    localparam logic [7:0] CVT_IDX_TERM_A = 8'h7e;
    localparam logic [7:0] CVT_IDX_TERM_B = 8'h7f;
    localparam logic [7:0] CVT_IDX_TADJ = 8'h80;
    localparam logic [7:0] CVT_IDX_STATUS = 8'h90;
    localparam int CVT_ADR_W = 10;
    localparam logic [7:0] CVT_ENABLE_RESET = 8'h00;
    localparam int CVT_ENABLE_BIT = 0;
    localparam int CVT_BG_W = 4;
    localparam logic [7:0] CVT_BG_MASK = 8'h0f;
    localparam int CVT_VEC_LEN = 673;
    localparam int CVT_IDX_W = 10;
    localparam logic [9:0] CVT_VEC_LAST = 10'h2a0;
    // status bit positions
    localparam int CVT_ST_HALTED = 0;
    localparam int CVT_ST_DONE = 1;
    localparam int CVT_ST_PARTIAL = 2;
    // factory trim defaults, arbitrary values
    localparam logic [7:0] CVT_FACT_GAIN_A = 8'h80;
    localparam logic [7:0] CVT_FACT_GAIN_B = 8'h80;
    localparam logic [7:0] CVT_FACT_BG = 8'h08;
    localparam logic [7:0] CVT_FACT_TERM_A = 8'h80;
    localparam logic [7:0] CVT_FACT_TERM_B = 8'h80;
    localparam logic [7:0] CVT_FACT_TADJ = 8'h80;
    typedef enum logic [1:0] {CVT_IDLE, CVT_ACK} cvt_bus_state_t;
endpackage

/* File: src/cvt_vector_store.sv */
/*
 * 673-entry calibration vector storage, flip-flops addressed by index
 * assumes one access per cycle from the register bank
 */
`timescale 1ns/10ps
`default_nettype none
module cvt_vector_store
    import cvt_pkg::*;
(
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [CVT_IDX_W-1:0] idx_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_q [CVT_VEC_LEN];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[idx_i] <= wdata_i;
        end
    end

    assign rdata_o = mem_q[idx_i];
endmodule // cvt_vector_store
`default_nettype wire

/* File: tb/testbench.sv */
/*
 * self-checking bench for the calibration vector and trim register bank
 * assumes cvt_calib_regs on a classic wishbone bus with one-cycle ack
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cvt_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [CVT_ADR_W-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic halted_i = 1'b1;
    logic [7:0] gain_a, gain_b, term_a, term_b, tadj;
    logic [3:0] bg;
    logic valid;
    logic [31:0] rd;
    int fail_count = 0;
    int checks = 0;

    always #2.5 clk_i = ~clk_i;

    cvt_calib_regs u_cvt_calib_regs (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .calibration_halted_status_i(halted_i),
        .gain_trim_first_channel_o(gain_a), .gain_trim_second_channel_o(gain_b),
        .bandgap_reference_trim_o(bg), .termination_trim_first_input_o(term_a),
        .termination_trim_second_input_o(term_b), .core_a_timing_adjust_fg_single_o(tadj),
        .vector_valid_o(valid)
    );

    task automatic tally_and_finish;
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask

    function automatic logic [7:0] vec(input int i);
        return 8'(i * 37 + 11);
    endfunction

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(CVT_IDX_ENABLE, {24'h0, CVT_ENABLE_RESET});
        rdchk(CVT_IDX_GAIN_A, {24'h0, CVT_FACT_GAIN_A});
        rdchk(CVT_IDX_GAIN_B, {24'h0, CVT_FACT_GAIN_B});
        rdchk(CVT_IDX_BG, {24'h0, CVT_FACT_BG & CVT_BG_MASK});
        rdchk(CVT_IDX_TERM_A, {24'h0, CVT_FACT_TERM_A});
        rdchk(CVT_IDX_TERM_B, {24'h0, CVT_FACT_TERM_B});
        rdchk(CVT_IDX_TADJ, {24'h0, CVT_FACT_TADJ});
        rdchk(CVT_IDX_PORT, 32'h0);
        wr(CVT_IDX_GAIN_A, 8'h5a);
        rdchk(CVT_IDX_GAIN_A, 32'h5a);
        chk({24'h0, gain_a}, 32'h5a);
        wr(CVT_IDX_GAIN_B, 8'ha3);
        rdchk(CVT_IDX_GAIN_B, 32'ha3);
        chk({24'h0, gain_b}, 32'ha3);
        wr(CVT_IDX_BG, 8'hf3);
        rdchk(CVT_IDX_BG, 32'h03);
        chk({28'h0, bg}, 32'h3);
        wr(CVT_IDX_TERM_A, 8'h01);
        rdchk(CVT_IDX_TERM_A, 32'h01);
        chk({24'h0, term_a}, 32'h01);
        wr(CVT_IDX_TERM_B, 8'hfe);
        rdchk(CVT_IDX_TERM_B, 32'hfe);
        chk({24'h0, term_b}, 32'hfe);
        wr(CVT_IDX_TADJ, 8'h3c);
        rdchk(CVT_IDX_TADJ, 32'h3c);
        chk({24'h0, tadj}, 32'h3c);
        // halted held high around port traffic
        wr(CVT_IDX_ENABLE, 8'h01);
        rdchk(CVT_IDX_ENABLE, 32'h01);
        for (int i = 0; i < CVT_VEC_LEN; i++) wr(CVT_IDX_PORT, vec(i));
        chk({31'h0, valid}, 32'h1);
        wr(CVT_IDX_ENABLE, 8'h00);
        wr(CVT_IDX_PORT, 8'h55);
        rdchk(CVT_IDX_PORT, 32'h0);
        wr(CVT_IDX_ENABLE, 8'h01);
        for (int i = 0; i < CVT_VEC_LEN; i++) rdchk(CVT_IDX_PORT, {24'h0, vec(i)});
        bus(1'b0, CVT_IDX_STATUS, 8'h00);
        chk({30'h0, rd[1:0]}, 32'h3);
        halted_i <= 1'b0;
        bus(1'b0, CVT_IDX_STATUS, 8'h00);
        chk({31'h0, rd[0]}, 32'h0);
        halted_i <= 1'b1;
        wr(CVT_IDX_ENABLE, 8'h00);
        wr(CVT_IDX_ENABLE, 8'h01);
        for (int i = 0; i < 3; i++) wr(CVT_IDX_PORT, 8'hc0 + 8'(i));
        chk({31'h0, valid}, 32'h0);
        wr(CVT_IDX_ENABLE, 8'h00);
        wr(CVT_IDX_ENABLE, 8'h01);
        rdchk(CVT_IDX_PORT, 32'hc0);
        rdchk(CVT_IDX_PORT, 32'hc1);
        wr(8'h75, 8'hff);
        rdchk(8'h75, 32'h0);
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
